// file: logic/bdx_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * decimal-adjust / decrement execution block.
 * Assumes inclusion by bare name from the block itself and the testbench.
 */
`ifndef BDX_MAP_SVH
`define BDX_MAP_SVH

// byte offsets on the avalon slave, one aligned word each
`define BDX_OFS_CMD      8'h00
`define BDX_OFS_ACC      8'h04
`define BDX_OFS_STATUS   8'h08
`define BDX_OFS_BANK     8'h0c
`define BDX_OFS_MADDR    8'h10
`define BDX_OFS_MDATA    8'h14

// command word fields
`define BDX_CMD_F_LSB    0
`define BDX_CMD_D_BIT    8
`define BDX_CMD_A_BIT    9
`define BDX_CMD_OP_BIT   10
`define BDX_CMD_BUSY_BIT 16

// status word fields
`define BDX_ST_C         0
`define BDX_ST_DIGIT_CARRY 1
`define BDX_ST_Z         2
`define BDX_ST_N         3

// reset values
`define BDX_RST_ACC      8'h00
`define BDX_RST_STATUS   4'h0
`define BDX_RST_CMD      11'h000

// bcd adjust constants
`define BDX_BCD_MAX      4'h9
`define BDX_BCD_ADJ      4'h6

// clocks per quarter phase
`define BDX_QDIV_DEF     1

`endif

// file: logic/bdx_pkg.sv
/*
 * Types of the decimal-adjust / decrement execution block.
 * Assumes bdx_map.svh is on the include path.
 */
package bdx_pkg;

    typedef enum logic {
        BDX_DECIMAL_ADJUST_OP,
        BDX_DECREMENT_FILE_OP
    } bdx_op_t;

    // instruction word as the decoder hands it over
    typedef struct packed {
        bdx_op_t op;
        logic a;
        logic d;
        logic [7:0] f;
    } bdx_cmd_t;

    typedef struct packed {
        logic n;
        logic z;
        logic digit_carry_flag;
        logic c;
    } bdx_flags_t;

    typedef enum logic [2:0] {
        BDX_IDLE,
        BDX_Q1,
        BDX_Q2,
        BDX_Q3,
        BDX_Q4
    } bdx_phase_t;

endpackage : bdx_pkg

// file: logic/bdx_exec.sv
/*
 * Execution datapath for the decimal adjust and decrement-file instructions,
 * with accumulator, flags, bank select and a banked file register array,
 * all reachable over an avalon-mm slave with waitrequest.
 * Assumes a single 100 MHz clock and that the bus master holds its request
 * until waitrequest is seen low.
 */
`timescale 1ns/100ps
`include "bdx_map.svh"

// Contract
// - low nibble above nine or dc: add six
// - high nibble above nine or carry: add six
// - decrement reads file register, result minus one
// - d zero to accumulator, one to file
// - a zero low bank, one bank select
module bdx_exec #(
    parameter int BANK_W = 2,
    parameter int QDIV = `BDX_QDIV_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // execution state
    output logic busy_out,
    output logic done_out
);
    import bdx_pkg::*;

    localparam int AW = BANK_W + 8;
    localparam int DEPTH = 1 << AW;

    // refused at elaboration: the quarter-phase divider counter is only 8 bits
    if (BANK_W < 1 || BANK_W > 4 || QDIV < 1 || QDIV > 256) begin : g_bad_param
        $error("bdx_exec: BANK_W must be 1..4 and QDIV 1..256");
    end

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : be_merge

    logic [7:0] acc_q;
    bdx_flags_t flags_q;
    logic [BANK_W-1:0] bank_sel_reg_q;
    bdx_cmd_t cmd_q;
    logic [AW-1:0] maddr_q;
    logic [7:0] mem_q [DEPTH];
    bdx_phase_t phase_q;
    logic [7:0] div_q;
    logic q_tick;
    logic [AW-1:0] op_addr_q;
    logic [7:0] operand_q;
    logic [7:0] result_q;
    bdx_flags_t res_flags_q;
    logic ack_q;
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic done_q;

    // bus slave: one wait cycle, writes stalled while an instruction runs
    logic req;
    logic allow;
    logic wr_go;
    logic start;
    assign req = avs_read_in | avs_write_in;
    assign allow = avs_read_in | (phase_q == BDX_IDLE);
    assign avs_waitrequest_out = req & ~ack_q;
    assign wr_go = avs_write_in & ack_q;
    assign start = wr_go && avs_address_in == `BDX_OFS_CMD;
    assign avs_readdata_out = rd_q;
    assign busy_out = phase_q != BDX_IDLE;
    assign done_out = done_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q & allow;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (avs_address_in)
            `BDX_OFS_CMD: begin
                rd_d[`BDX_CMD_OP_BIT:0] = cmd_q;
                rd_d[`BDX_CMD_BUSY_BIT] = busy_out;
            end
            `BDX_OFS_ACC: rd_d[7:0] = acc_q;
            `BDX_OFS_STATUS: rd_d[3:0] = flags_q;
            `BDX_OFS_BANK: rd_d[BANK_W-1:0] = bank_sel_reg_q;
            `BDX_OFS_MADDR: rd_d[AW-1:0] = maddr_q;
            `BDX_OFS_MDATA: rd_d[7:0] = mem_q[maddr_q];
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_q <= 32'h0000_0000;
        end else if (avs_read_in & ~ack_q) begin
            rd_q <= rd_d;
        end
    end

    // quarter-phase enable, restarted with each instruction so phases are exact
    always_ff @(posedge clk_in) begin
        if (rst_in || start || q_tick) begin
            div_q <= 8'h00;
        end else if (busy_out) begin
            div_q <= div_q + 8'h01;
        end
    end
    assign q_tick = busy_out && div_q == 8'(QDIV - 1);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_q <= BDX_IDLE;
        end else begin
            unique case (phase_q)
                BDX_IDLE: if (start) phase_q <= BDX_Q1;
                BDX_Q1: if (q_tick) phase_q <= BDX_Q2;
                BDX_Q2: if (q_tick) phase_q <= BDX_Q3;
                BDX_Q3: if (q_tick) phase_q <= BDX_Q4;
                BDX_Q4: if (q_tick) phase_q <= BDX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            done_q <= 1'b0;
        end else begin
            done_q <= phase_q == BDX_Q4 && q_tick;
        end
    end

    // software-visible control words
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cmd_q <= `BDX_RST_CMD;
            bank_sel_reg_q <= '0;
            maddr_q <= '0;
        end else if (wr_go) begin
            unique case (avs_address_in)
                `BDX_OFS_CMD: cmd_q <= 11'(be_merge(32'(cmd_q), avs_writedata_in, avs_byteenable_in));
                `BDX_OFS_BANK: bank_sel_reg_q <= BANK_W'(be_merge(32'(bank_sel_reg_q), avs_writedata_in,
                    avs_byteenable_in));
                `BDX_OFS_MADDR: maddr_q <= AW'(be_merge(32'(maddr_q), avs_writedata_in, avs_byteenable_in));
                default: ;
            endcase
        end
    end

    // decode: operand address, access bank ignores the bank select
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_addr_q <= '0;
        end else if (phase_q == BDX_Q1 && q_tick) begin
            op_addr_q <= cmd_q.a ? {bank_sel_reg_q, cmd_q.f} : {{BANK_W{1'b0}}, cmd_q.f};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            operand_q <= 8'h00;
        end else if (phase_q == BDX_Q2 && q_tick) begin
            operand_q <= cmd_q.op == BDX_DECREMENT_FILE_OP ? mem_q[op_addr_q] : acc_q;
        end
    end

    // process data
    logic lo_adj;
    logic hi_adj;
    logic [8:0] adj_lo_sum;
    logic [8:0] adj_sum;
    logic [7:0] dec_r;
    always_comb begin
        lo_adj = operand_q[3:0] > `BDX_BCD_MAX || flags_q.digit_carry_flag;
        adj_lo_sum = {1'b0, operand_q} + (lo_adj ? {5'h00, `BDX_BCD_ADJ} : 9'h000);
        hi_adj = adj_lo_sum[7:4] > `BDX_BCD_MAX || flags_q.c || adj_lo_sum[8];
        adj_sum = {1'b0, adj_lo_sum[7:0]} + (hi_adj ? {1'b0, `BDX_BCD_ADJ, 4'h0} : 9'h000);
        dec_r = operand_q - 8'h01;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            result_q <= 8'h00;
            res_flags_q <= `BDX_RST_STATUS;
        end else if (phase_q == BDX_Q3 && q_tick) begin
            if (cmd_q.op == BDX_DECIMAL_ADJUST_OP) begin
                result_q <= adj_sum[7:0];
                // only carry changes on an adjust
                res_flags_q <= {flags_q.n, flags_q.z, flags_q.digit_carry_flag, flags_q.c | adj_lo_sum[8] | adj_sum[8]};
            end else begin
                result_q <= dec_r;
                res_flags_q <= {dec_r[7], dec_r == 8'h00, operand_q[3:0] != 4'h0, operand_q != 8'h00};
            end
        end
    end

    // write destination in the last quarter
    logic wb;
    logic wb_acc;
    assign wb = phase_q == BDX_Q4 && q_tick;
    assign wb_acc = cmd_q.op == BDX_DECIMAL_ADJUST_OP || !cmd_q.d;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc_q <= `BDX_RST_ACC;
            flags_q <= `BDX_RST_STATUS;
        end else if (wb) begin
            flags_q <= res_flags_q;
            if (wb_acc) begin
                acc_q <= result_q;
            end
        end else if (wr_go && avs_address_in == `BDX_OFS_ACC) begin
            acc_q <= 8'(be_merge(32'(acc_q), avs_writedata_in, avs_byteenable_in));
        end else if (wr_go && avs_address_in == `BDX_OFS_STATUS) begin
            flags_q <= 4'(be_merge(32'(flags_q), avs_writedata_in, avs_byteenable_in));
        end
    end

    // file registers are not reset, like ordinary data ram
    always_ff @(posedge clk_in) begin
        if (wb && !wb_acc) begin
            mem_q[op_addr_q] <= result_q;
        end else if (wr_go && avs_address_in == `BDX_OFS_MDATA && avs_byteenable_in[0]) begin
            mem_q[maddr_q] <= avs_writedata_in[7:0];
        end
    end

    // helper snapshots for the checks below
    logic [7:0] s_acc_q;
    logic [7:0] s_opnd_q;
    bdx_flags_t s_flags_q;
    logic [BANK_W-1:0] s_bank_q;
    logic [11:0] s_cyc_q;
    logic s_lc;
    always_ff @(posedge clk_in) begin
        if (start) begin
            s_acc_q <= acc_q;
            s_flags_q <= flags_q;
            s_bank_q <= bank_sel_reg_q;
            s_cyc_q <= 12'h000;
        end else if (busy_out) begin
            s_cyc_q <= s_cyc_q + 12'h001;
        end
        if (phase_q == BDX_Q1 && q_tick) begin
            s_opnd_q <= cmd_q.a ? mem_q[{bank_sel_reg_q, cmd_q.f}] : mem_q[{{BANK_W{1'b0}}, cmd_q.f}];
        end
    end
    assign s_lc = (s_acc_q[3:0] > `BDX_BCD_MAX || s_flags_q.digit_carry_flag) && s_acc_q[3:0] > 4'h9;

    a_bcd_low_nibble: assert property (@(posedge clk_in) disable iff (rst_in)
        done_q && cmd_q.op == BDX_DECIMAL_ADJUST_OP |-> acc_q[3:0] ==
        ((s_acc_q[3:0] > 4'h9 || s_flags_q.digit_carry_flag) ? s_acc_q[3:0] + 4'h6 : s_acc_q[3:0]))
        else $error("decimal adjust low nibble wrong");
    a_bcd_high_nibble: assert property (@(posedge clk_in) disable iff (rst_in)
        done_q && cmd_q.op == BDX_DECIMAL_ADJUST_OP && (s_acc_q[7:4] > 4'h9 || s_flags_q.c)
        |-> flags_q.c && acc_q[7:4] == s_acc_q[7:4] + 4'h6 + {3'b000, s_lc})
        else $error("decimal adjust high nibble or carry wrong");
    a_dec_to_acc: assert property (@(posedge clk_in) disable iff (rst_in)
        done_q && cmd_q.op == BDX_DECREMENT_FILE_OP && !cmd_q.d |-> acc_q == s_opnd_q - 8'h01)
        else $error("decrement result to accumulator wrong");
    a_dec_to_file: assert property (@(posedge clk_in) disable iff (rst_in)
        done_q && cmd_q.op == BDX_DECREMENT_FILE_OP && cmd_q.d
        |-> mem_q[op_addr_q] == s_opnd_q - 8'h01 && $stable(acc_q))
        else $error("decrement result to file register wrong");
    a_bank_mapping: assert property (@(posedge clk_in) disable iff (rst_in)
        phase_q == BDX_Q2 |-> op_addr_q == (cmd_q.a ? {s_bank_q, cmd_q.f} : {{BANK_W{1'b0}}, cmd_q.f}))
        else $error("operand bank mapping wrong");
    a_cycle_length: assert property (@(posedge clk_in) disable iff (rst_in)
        phase_q == BDX_Q4 && q_tick |-> s_cyc_q == 12'(4 * QDIV - 1))
        else $error("instruction cycle length wrong");
    a_start_phase: assert property (@(posedge clk_in) disable iff (rst_in)
        start |=> phase_q == BDX_Q1)
        else $error("instruction did not begin with decode");

endmodule : bdx_exec

// file: tb/bdx_avs_master.sv
/* avalon-mm master model standing in for the decoder side of the exec block.
   assumes one clock and a slave that stalls with waitrequest. */
`timescale 1ns/100ps
module bdx_avs_master (
    // clock
    input wire logic clk_in,
    // slave answer
    input wire logic avs_waitrequest_in,
    input wire logic [31:0] avs_readdata_in,
    // request
    output logic [7:0] avs_address_out,
    output logic avs_read_out,
    output logic avs_write_out,
    output logic [31:0] avs_writedata_out,
    output logic [3:0] avs_byteenable_out
);
    initial begin
        avs_address_out <= 8'h00;
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        avs_writedata_out <= 32'h0;
        avs_byteenable_out <= 4'hf;
    end

    // a free edge before raising keeps back-to-back calls from double driving
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic [3:0] be,
                          output logic [31:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 32'h0;
        @(posedge clk_in);
        avs_address_out <= addr;
        avs_write_out <= wr;
        avs_read_out <= !wr;
        avs_writedata_out <= wdata;
        avs_byteenable_out <= be;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_in);
            if (avs_waitrequest_in === 1'b0) begin
                rdata = avs_readdata_in;
                ok = 1'b1;
                break;
            end
        end
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        // released lines must not keep showing the old value
        avs_address_out <= ~addr;
        avs_writedata_out <= ~wdata;
    endtask : access
endmodule : bdx_avs_master

// file: tb/test_bcd_adjust_and_decrement_exec.sv
/* self-checking bench for bdx_exec: decimal adjust, decrement and timing.
   assumes bdx_avs_master drives the slave port and QDIV is raised to 2. */
`timescale 1ns/100ps
`include "bdx_map.svh"
module test_bcd_adjust_and_decrement_exec;
    import bdx_pkg::*;
    localparam int QD = 2;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] adr;
    logic rd_s, wr_s, wreq, busy, done;
    logic [31:0] wdat, rdat;
    logic [3:0] be;
    int n_errors = 0;
    int checked = 0;
    logic [9:0] bcd_tab [8] = '{10'h0a5, 10'h0ce, 10'h112, 10'h212, 10'h099, 10'h09a, 10'h300, 10'h0fa};
    // bank, a, d, f, bank-0 value, selected-bank value
    logic [27:0] dec_tab [4] = '{28'hbff3301, 28'hc100044, 28'h6005580, 28'hd201899};

    always #5 clk_in = ~clk_in;

    bdx_avs_master m (.clk_in(clk_in), .avs_waitrequest_in(wreq), .avs_readdata_in(rdat),
        .avs_address_out(adr), .avs_read_out(rd_s), .avs_write_out(wr_s),
        .avs_writedata_out(wdat), .avs_byteenable_out(be));
    bdx_exec #(.BANK_W(2), .QDIV(QD)) dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .busy_out(busy), .done_out(done));

    task automatic stop_test();
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] lanes,
                       output logic [31:0] rv);
        logic ok;
        m.access(wr, a, wd, lanes, rv, ok);
        if (!ok) begin
            $display("mismatch %0t bus answer never came", $time);
            n_errors++;
            stop_test();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] rv;
        bus(1'b1, a, wd, 4'hf, rv);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rv;
        bus(1'b0, a, 32'h0, 4'hf, rv);
        chk(rv, exp);
    endtask : rchk

    // start an instruction and count cycles up to the done pulse
    task automatic exec(input logic [31:0] cmd);
        int n;
        wr(`BDX_OFS_CMD, cmd);
        for (n = 1; n < 300; n++) begin
            @(negedge clk_in);
            if (n == 1) chk({31'h0, busy}, 32'h1);
            if (done === 1'b1) break;
        end
        chk(n, 4 * QD + 1);
        chk({31'h0, busy}, 32'h0);
        if (n == 300) begin
            stop_test();
        end
        // the done pulse lasts one cycle only
        @(negedge clk_in);
        chk({31'h0, done}, 32'h0);
    endtask : exec

    function automatic logic [8:0] bcd_adj(input logic [7:0] w, input logic c, input logic hc);
        logic [8:0] t;
        t = {1'b0, w};
        if (w[3:0] > 4'h9 || hc) t = t + 9'h006;
        if (t[7:4] > 4'h9 || c || t[8]) t = t + 9'h060;
        return {t[8] | c, t[7:0]};
    endfunction : bcd_adj

    initial begin
        logic [8:0] e;
        logic [27:0] t;
        logic [9:0] sa, oa;
        logic [7:0] v, ov, r;
        logic [31:0] rv;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rchk(`BDX_OFS_ACC, 32'h0);
        rchk(`BDX_OFS_STATUS, 32'h0);
        wr(8'h18, 32'h5a);
        rchk(8'h18, 32'h0);
        foreach (bcd_tab[i]) begin
            wr(`BDX_OFS_STATUS, {30'h0, bcd_tab[i][8], bcd_tab[i][9]});
            wr(`BDX_OFS_ACC, {24'h0, bcd_tab[i][7:0]});
            exec(32'h0);
            e = bcd_adj(bcd_tab[i][7:0], bcd_tab[i][9], bcd_tab[i][8]);
            rchk(`BDX_OFS_ACC, {24'h0, e[7:0]});
            rchk(`BDX_OFS_STATUS, {30'h0, bcd_tab[i][8], e[8]});
        end
        foreach (dec_tab[i]) begin
            t = dec_tab[i];
            sa = t[25] ? {t[27:26], t[23:16]} : {2'b00, t[23:16]};
            oa = t[25] ? {2'b00, t[23:16]} : {t[27:26], t[23:16]};
            v = t[25] ? t[7:0] : t[15:8];
            ov = t[25] ? t[15:8] : t[7:0];
            r = v - 8'h01;
            wr(`BDX_OFS_MADDR, {24'h0, t[23:16]});
            wr(`BDX_OFS_MDATA, {24'h0, t[15:8]});
            wr(`BDX_OFS_MADDR, {22'h0, t[27:26], t[23:16]});
            wr(`BDX_OFS_MDATA, {24'h0, t[7:0]});
            wr(`BDX_OFS_BANK, {30'h0, t[27:26]});
            wr(`BDX_OFS_ACC, 32'hc3);
            exec({21'h0, 1'b1, t[25], t[24], t[23:16]});
            rchk(`BDX_OFS_CMD, {21'h0, 1'b1, t[25], t[24], t[23:16]});
            rchk(`BDX_OFS_BANK, {30'h0, t[27:26]});
            wr(`BDX_OFS_MADDR, {22'h0, sa});
            rchk(`BDX_OFS_MDATA, {24'h0, t[24] ? r : v});
            rchk(`BDX_OFS_ACC, {24'h0, t[24] ? 8'hc3 : r});
            rchk(`BDX_OFS_STATUS, {28'h0, r[7], r == 8'h00, v[3:0] != 4'h0, v != 8'h00});
            wr(`BDX_OFS_MADDR, {22'h0, oa});
            rchk(`BDX_OFS_MDATA, {24'h0, ov});
        end
        // disabled byte lanes leave their bits alone
        wr(`BDX_OFS_ACC, 32'h11);
        bus(1'b1, `BDX_OFS_ACC, 32'hff, 4'he, rv);
        rchk(`BDX_OFS_ACC, 32'h11);
        wr(`BDX_OFS_MADDR, 32'h05);
        wr(`BDX_OFS_MDATA, 32'h77);
        bus(1'b1, `BDX_OFS_MDATA, 32'h88, 4'he, rv);
        rchk(`BDX_OFS_MDATA, 32'h77);
        bus(1'b1, `BDX_OFS_ACC, 32'hff22, 4'h1, rv);
        rchk(`BDX_OFS_ACC, 32'h22);
        // a write during a running instruction is held until it ends
        wr(`BDX_OFS_ACC, 32'h0a);
        wr(`BDX_OFS_CMD, 32'h0);
        wr(`BDX_OFS_ACC, 32'h5a);
        chk({31'h0, busy}, 32'h0);
        rchk(`BDX_OFS_ACC, 32'h5a);
        stop_test();
    end
endmodule : test_bcd_adjust_and_decrement_exec
